// ===== design/rcr_params.svh
// Purpose: Constants of the regulator configuration register block
// Assumes: 100 MHz i_clk; frequency input in units of 1/8 kHz
// Notes: Option-dependent reset values hold the first factory option
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

`define RCR_ADDR_VERSION 8'h00
`define RCR_ADDR_CTRL 8'h01
`define RCR_ADDR_VT 8'h02
`define RCR_ADDR_LAST 8'h02

`define RCR_CTRL_RST 8'hF0
`define RCR_THR_RST 2'h3
`define RCR_OUTPUT_VOLTAGE_CODE_RST 6'h28
`define RCR_VCODE_MAX 6'h2E

`define RCR_CLK_PERIOD_NS 10
`define RCR_RAMP_STEP_NS 50000
`define RCR_RAMP_STEP_CYC ((`RCR_RAMP_STEP_NS) / (`RCR_CLK_PERIOD_NS))

`define RCR_RISE_SEL0 12'h0C8
`define RCR_RISE_SEL1 12'h118
`define RCR_RISE_SEL2 12'h190
`define RCR_RISE_SEL3 12'h320
`define RCR_FALL_SEL0 12'h031
`define RCR_FALL_SEL1 12'h042
`define RCR_FALL_SEL2 12'h064
`define RCR_FALL_SEL3 12'h0C8

`endif

// ===== design/rcr_pkg.sv
// Purpose: Types of the regulator configuration register block
// Assumes: Field order gives bit positions, msb first
// Notes: None
package rcr_pkg;

  typedef struct packed {
    logic output_on;
    logic voltage_ramp_on;
    logic fast_response_sel;
    logic zero_cross_comparator_off;
    logic slow_edge_sel;
    logic topology_sel;
    logic active_discharge_sel;
    logic passive_discharge_sel;
  } rcr_ctrl_t;

  typedef struct packed {
    logic [1:0] high_freq_threshold_sel;
    logic [5:0] output_voltage_code;
  } rcr_vt_t;

  typedef enum logic {
    RCR_IDLE,
    RCR_RAMP
  } rcr_ramp_st_t;

endpackage

// ===== design/rcr_vramp.sv
// Purpose: Output voltage code stepping
// Assumes: Target comes from the voltage register
// Notes: One code step per step period while rising
`timescale 1ns/10ps
`include "rcr_params.svh"

module rcr_vramp
  import rcr_pkg::*;
#(
  parameter int STEP_CYC = `RCR_RAMP_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ramp_on,
  input wire logic [5:0] i_target,
  output logic [5:0] o_vcode,
  output logic o_busy
);

  localparam int CW = $clog2(STEP_CYC + 1);

  rcr_ramp_st_t st_ff;
  rcr_ramp_st_t nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [5:0] vcode_ff;
  logic [5:0] nxt_vcode;

  // Clamp of high codes
  wire [5:0] tgt_clamp = (i_target > `RCR_VCODE_MAX) ? `RCR_VCODE_MAX : i_target;
  wire go_up = i_ramp_on && (tgt_clamp > vcode_ff);
  wire step_due = (cnt_ff == CW'(STEP_CYC - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = '0;
    nxt_vcode = vcode_ff;
    unique case (st_ff)
      RCR_IDLE: begin
        if (go_up) begin
          nxt_st = RCR_RAMP;
        end else begin
          nxt_vcode = tgt_clamp;
        end
      end
      RCR_RAMP: begin
        if (!go_up) begin
          nxt_st = RCR_IDLE;
          nxt_vcode = tgt_clamp;
        end else if (step_due) begin
          nxt_vcode = vcode_ff + 6'h01;
        end else begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_ff <= RCR_IDLE;
      cnt_ff <= '0;
      vcode_ff <= `RCR_OUTPUT_VOLTAGE_CODE_RST;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      vcode_ff <= nxt_vcode;
    end
  end

  assign o_vcode = vcode_ff;
  assign o_busy = (st_ff == RCR_RAMP);

  property p_clamp;
    @(posedge i_clk) disable iff (!i_rst_b) o_vcode <= `RCR_VCODE_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("voltage code above clamp");

  property p_down_now;
    @(posedge i_clk) disable iff (!i_rst_b)
      (tgt_clamp < o_vcode) |=> (o_vcode == $past(tgt_clamp));
  endproperty
  a_down_now: assert property (p_down_now) else $error("decrease not immediate");

  property p_no_ramp;
    @(posedge i_clk) disable iff (!i_rst_b)
      !i_ramp_on |=> (o_vcode == $past(tgt_clamp));
  endproperty
  a_no_ramp: assert property (p_no_ramp) else $error("unramped change not immediate");

  property p_step_timed;
    @(posedge i_clk) disable iff (!i_rst_b)
      (o_vcode > $past(o_vcode)) && $past(i_ramp_on) && $past(o_busy)
        |-> (o_vcode == $past(o_vcode) + 6'h01) && $past(step_due);
  endproperty
  a_step_timed: assert property (p_step_timed) else $error("bad ramp step");

endmodule

// ===== design/rcr_config_regs.sv
// Purpose: Configuration and version registers of the buck-boost regulator
// Assumes: Byte strobes come from the serial slave engine on i_clk
// Notes: Frequency input comes from an on-chip meter on i_clk
`timescale 1ns/10ps
`include "rcr_params.svh"

module rcr_config_regs
  import rcr_pkg::*;
#(
  // Arbitrary value, not a real part code
  parameter logic [7:0] CHIP_VERSION = 8'hA5,
  parameter int RAMP_STEP_CYC = `RCR_RAMP_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_addr,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_stb,
  input wire logic [11:0] i_sw_freq_q3,
  output logic o_addr_ack,
  output logic [7:0] o_rdata,
  output logic o_output_on,
  output logic o_fast_response,
  output logic o_zero_cross_off,
  output logic o_slow_edge,
  output logic o_buck_only,
  output logic o_active_discharge,
  output logic o_passive_discharge,
  output logic [1:0] o_freq_thresh_sel,
  output logic o_all_blocks_on,
  output logic [5:0] o_vout_code,
  output logic o_ramp_busy
);

  rcr_ctrl_t ctrl_ff;
  rcr_ctrl_t nxt_ctrl;
  rcr_vt_t vt_ff;
  rcr_vt_t nxt_vt;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic zc_act_ff;
  logic nxt_zc_act;
  logic topo_act_ff;
  logic nxt_topo_act;
  logic hi_ff;
  logic nxt_hi;

  // Access decode
  wire wr_go = i_wr_stb && !i_ptr_load;
  wire rd_go = i_rd_stb && !i_ptr_load;
  wire acc_go = wr_go || rd_go;
  wire at_version = (ptr_ff == `RCR_ADDR_VERSION);
  wire wr_ctrl = wr_go && (ptr_ff == `RCR_ADDR_CTRL);
  wire wr_vt = wr_go && (ptr_ff == `RCR_ADDR_VT);

  // Address acknowledge for the engine
  assign o_addr_ack = (i_ptr_addr <= `RCR_ADDR_LAST);

  // Pointer stepping, held at address 0
  assign nxt_ptr = i_ptr_load ? i_ptr_addr :
                   (acc_go && !at_version) ? ptr_ff + 8'h01 :
                   ptr_ff;

  // Register writes, version not writable
  assign nxt_ctrl = wr_ctrl ? rcr_ctrl_t'(i_wdata) : ctrl_ff;
  assign nxt_vt = wr_vt ? rcr_vt_t'(i_wdata) : vt_ff;

  // Read selection
  wire [7:0] rd_val = at_version ? CHIP_VERSION :
                      (ptr_ff == `RCR_ADDR_CTRL) ? ctrl_ff :
                      (ptr_ff == `RCR_ADDR_VT) ? vt_ff :
                      8'h00;
  assign nxt_rdata = rd_go ? rd_val : rdata_ff;

  // Latched copies reload only while the output is off
  assign nxt_zc_act = ctrl_ff.output_on ? zc_act_ff :
                      ctrl_ff.zero_cross_comparator_off;
  assign nxt_topo_act = ctrl_ff.output_on ? topo_act_ff :
                        ctrl_ff.topology_sel;

  // Frequency thresholds
  wire [1:0] thr_sel = vt_ff.high_freq_threshold_sel;
  wire [11:0] rise_thr = (thr_sel == 2'h0) ? `RCR_RISE_SEL0 :
                         (thr_sel == 2'h1) ? `RCR_RISE_SEL1 :
                         (thr_sel == 2'h2) ? `RCR_RISE_SEL2 :
                         `RCR_RISE_SEL3;
  wire [11:0] fall_thr = (thr_sel == 2'h0) ? `RCR_FALL_SEL0 :
                         (thr_sel == 2'h1) ? `RCR_FALL_SEL1 :
                         (thr_sel == 2'h2) ? `RCR_FALL_SEL2 :
                         `RCR_FALL_SEL3;

  // Hysteresis on all-blocks-on
  assign nxt_hi = (i_sw_freq_q3 > rise_thr) ? 1'b1 :
                  (i_sw_freq_q3 <= fall_thr) ? 1'b0 :
                  hi_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_ff <= rcr_ctrl_t'(`RCR_CTRL_RST);
      vt_ff <= {`RCR_THR_RST, `RCR_OUTPUT_VOLTAGE_CODE_RST};
      ptr_ff <= `RCR_ADDR_VERSION;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      vt_ff <= nxt_vt;
      ptr_ff <= nxt_ptr;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      zc_act_ff <= 1'b1;
      topo_act_ff <= 1'b0;
      hi_ff <= 1'b0;
    end else begin
      zc_act_ff <= nxt_zc_act;
      topo_act_ff <= nxt_topo_act;
      hi_ff <= nxt_hi;
    end
  end

  // Voltage stepping
  rcr_vramp #(
    .STEP_CYC(RAMP_STEP_CYC)
  ) u_ramp (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ramp_on(ctrl_ff.voltage_ramp_on),
    .i_target(vt_ff.output_voltage_code),
    .o_vcode(o_vout_code),
    .o_busy(o_ramp_busy)
  );

  // Read data and controls to the power stage
  assign o_rdata = rdata_ff;
  assign o_output_on = ctrl_ff.output_on;
  assign o_fast_response = ctrl_ff.fast_response_sel;
  assign o_zero_cross_off = zc_act_ff;
  assign o_slow_edge = ctrl_ff.slow_edge_sel;
  assign o_buck_only = topo_act_ff;
  assign o_active_discharge = !ctrl_ff.output_on && ctrl_ff.active_discharge_sel;
  assign o_passive_discharge = !ctrl_ff.output_on && ctrl_ff.passive_discharge_sel;
  assign o_freq_thresh_sel = thr_sel;
  assign o_all_blocks_on = hi_ff;

  // Checks
  sequence s_rd_ver;
    rd_go && at_version;
  endsequence

  sequence s_wr_ver;
    wr_go && at_version;
  endsequence

  sequence s_wr_ctrl;
    wr_ctrl;
  endsequence

  sequence s_above;
    i_sw_freq_q3 > rise_thr;
  endsequence

  sequence s_below;
    i_sw_freq_q3 <= fall_thr;
  endsequence

  sequence s_rd_ctrl;
    rd_go && (ptr_ff == `RCR_ADDR_CTRL);
  endsequence

  sequence s_rd_vt;
    rd_go && (ptr_ff == `RCR_ADDR_VT);
  endsequence

  sequence s_wr_vt;
    wr_vt;
  endsequence

  property p_ver_read;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_rd_ver |=> (o_rdata == CHIP_VERSION);
  endproperty
  a_ver_read: assert property (p_ver_read) else $error("version read wrong");

  property p_ver_ro;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_wr_ver |=> (ctrl_ff == $past(ctrl_ff)) && (vt_ff == $past(vt_ff))
        && (ptr_ff == `RCR_ADDR_VERSION);
  endproperty
  a_ver_ro: assert property (p_ver_ro) else $error("version write had effect");

  property p_ptr_step;
    @(posedge i_clk) disable iff (!i_rst_b)
      acc_go && !at_version |=> (ptr_ff == $past(ptr_ff) + 8'h01);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

  property p_en_write;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_wr_ctrl |=> (o_output_on == $past(i_wdata[7]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("output enable not written");

  property p_mode_bits;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_wr_ctrl |=> (o_fast_response == $past(i_wdata[5]))
        && (o_slow_edge == $past(i_wdata[3]));
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits bad");

  property p_latch_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_output_on |=> $stable(o_zero_cross_off) && $stable(o_buck_only);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

  property p_latch_load;
    @(posedge i_clk) disable iff (!i_rst_b)
      !o_output_on |=> (o_buck_only == $past(ctrl_ff.topology_sel))
        && (o_zero_cross_off == $past(ctrl_ff.zero_cross_comparator_off));
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latched field not loaded");

  property p_discharge;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_wr_ctrl ##0 (!i_wdata[7]) |=> (o_active_discharge == $past(i_wdata[1]))
        && (o_passive_discharge == $past(i_wdata[0]));
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge bad");

  property p_hyst_rise;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_above |=> o_all_blocks_on;
  endproperty
  a_hyst_rise: assert property (p_hyst_rise) else $error("blocks off");

  property p_hyst_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_all_blocks_on && (i_sw_freq_q3 > fall_thr) |=> o_all_blocks_on;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("blocks released early");

  property p_hyst_fall;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_below |=> !o_all_blocks_on;
  endproperty
  a_hyst_fall: assert property (p_hyst_fall) else $error("blocks not released");

  property p_hyst_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
      !o_all_blocks_on && (i_sw_freq_q3 <= rise_thr) |=> !o_all_blocks_on;
  endproperty
  a_hyst_idle: assert property (p_hyst_idle) else $error("blocks on too soon");

  property p_rd_ctrl;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_rd_ctrl |=> (o_rdata == $past(ctrl_ff));
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_vt;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_rd_vt |=> (o_rdata == $past(vt_ff));
  endproperty
  a_rd_vt: assert property (p_rd_vt) else $error("voltage read wrong");

  property p_rd_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      !rd_go |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_ptr_load;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_ptr_load |=> (ptr_ff == $past(i_ptr_addr));
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_ptr_ver;
    @(posedge i_clk) disable iff (!i_rst_b)
      acc_go && at_version |=> (ptr_ff == `RCR_ADDR_VERSION);
  endproperty
  a_ptr_ver: assert property (p_ptr_ver) else $error("pointer left address 0");

  property p_load_wins;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_ptr_load |=> $stable(ctrl_ff) && $stable(vt_ff);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("write during address");

  property p_ctrl_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      !wr_ctrl |=> $stable(ctrl_ff);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");

  property p_vt_write;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_wr_vt |=> (vt_ff == $past(i_wdata));
  endproperty
  a_vt_write: assert property (p_vt_write) else $error("voltage not written");

  property p_vt_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      !wr_vt |=> $stable(vt_ff);
  endproperty
  a_vt_hold: assert property (p_vt_hold) else $error("voltage moved");

endmodule

// ===== verif/rcr_host_model.sv
// Purpose: Byte-level host model on the register port
// Assumes: Requests change just after a rising edge of i_clk
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/10ps

module rcr_host_model (
  input wire logic i_clk,
  input wire logic i_addr_ack,
  input wire logic [7:0] i_rdata,
  output logic o_ptr_load,
  output logic [7:0] o_ptr_addr,
  output logic o_wr_stb,
  output logic [7:0] o_wdata,
  output logic o_rd_stb
);
  initial begin
    o_ptr_load = 1'b0;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
  end

  // Register address byte before data bytes
  task automatic set_ptr(input logic [7:0] addr, output logic ack);
    @(posedge i_clk);
    o_ptr_load <= 1'b1;
    o_ptr_addr <= addr;
    #1;
    ack = i_addr_ack;
    @(posedge i_clk);
    o_ptr_load <= 1'b0;
    o_ptr_addr <= ~addr;
    #1;
  endtask

  task automatic wr(input logic [7:0] data);
    @(posedge i_clk);
    o_wr_stb <= 1'b1;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_wdata <= ~data;
    #1;
  endtask

  task automatic rd(output logic [7:0] data);
    @(posedge i_clk);
    o_rd_stb <= 1'b1;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    #1;
    data = i_rdata;
  endtask
endmodule

// ===== verif/rcr_config_regs_test.sv
// Purpose: Self-checking bench of the configuration registers
// Assumes: Short ramp step period for simulation
// Notes: Host model drives the register port
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp); \
    end \
  end

module rcr_config_regs_test
  import rcr_pkg::*;
;
  localparam int STEP = 8;
  // Arbitrary value, not a real part code
  localparam logic [7:0] VER = 8'h3C;
  localparam logic [47:0] RISE_T = {12'h320, 12'h190, 12'h118, 12'h0C8};
  localparam logic [47:0] FALL_T = {12'h0C8, 12'h064, 12'h042, 12'h031};

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] freq;
  logic ptr_load, wr_stb, rd_stb, ack_w, on, fast, zc, slow, buck, act, psv, all_on, busy;
  logic [7:0] ptr_addr, wdata, rdata;
  logic [1:0] thr;
  logic [5:0] vout;
  int err_count = 0;
  int checked = 0;

  always #5 clk = ~clk;

  rcr_config_regs #(.CHIP_VERSION(VER), .RAMP_STEP_CYC(STEP)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ptr_load(ptr_load), .i_ptr_addr(ptr_addr),
    .i_wr_stb(wr_stb), .i_wdata(wdata), .i_rd_stb(rd_stb), .i_sw_freq_q3(freq),
    .o_addr_ack(ack_w), .o_rdata(rdata), .o_output_on(on), .o_fast_response(fast),
    .o_zero_cross_off(zc), .o_slow_edge(slow), .o_buck_only(buck),
    .o_active_discharge(act), .o_passive_discharge(psv), .o_freq_thresh_sel(thr),
    .o_all_blocks_on(all_on), .o_vout_code(vout), .o_ramp_busy(busy)
  );

  rcr_host_model host (
    .i_clk(clk), .i_addr_ack(ack_w), .i_rdata(rdata), .o_ptr_load(ptr_load),
    .o_ptr_addr(ptr_addr), .o_wr_stb(wr_stb), .o_wdata(wdata), .o_rd_stb(rd_stb)
  );

  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] d;
    host.rd(d);
    `CHK(d, exp);
  endtask

  task automatic t_reset();
    logic ack;
    `CHK(rdata, 8'h00);
    `CHK({on, fast, zc, slow, buck, act, psv}, 7'b1110_000);
    `CHK({thr, vout, busy, all_on}, 10'h3A0);
    host.set_ptr(8'h01, ack);
    rd_chk(8'hF0);
    rd_chk(8'hE8);
  endtask

  task automatic t_version();
    logic ack;
    host.set_ptr(8'h00, ack);
    `CHK(ack, 1'b1);
    rd_chk(VER);
    host.wr(8'h5A);
    rd_chk(VER);
  endtask

  task automatic t_burst();
    logic ack;
    rcr_ctrl_t c;
    c = 8'h0B;
    host.set_ptr(8'h01, ack);
    host.wr(c);
    host.wr(8'h68);
    `CHK({on, fast, slow}, {c.output_on, c.fast_response_sel, c.slow_edge_sel});
    `CHK({act, psv}, 2'b11);
    `CHK(thr, 2'h1);
    host.set_ptr(8'h01, ack);
    rd_chk(8'h0B);
    rd_chk(8'h68);
    rd_chk(8'h00);
    host.set_ptr(8'h03, ack);
    `CHK(ack, 1'b0);
  endtask

  task automatic ctrl_wr(input logic [7:0] d);
    logic ack;
    host.set_ptr(8'h01, ack);
    host.wr(d);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_latched();
    logic ack;
    ctrl_wr(8'h04);
    `CHK({zc, buck}, 2'b01);
    ctrl_wr(8'h84);
    `CHK({on, act, psv}, 3'b100);
    ctrl_wr(8'h90);
    `CHK({zc, buck}, 2'b01);
    host.set_ptr(8'h01, ack);
    rd_chk(8'h90);
    rd_chk(8'h68);
    ctrl_wr(8'h10);
    `CHK({zc, buck}, 2'b10);
  endtask

  task automatic wait_code(input logic [5:0] c);
    int last;
    logic [5:0] prev;
    last = 0;
    prev = vout;
    for (int n = 1; n <= 60 && prev !== c; n++) begin
      @(posedge clk);
      #1;
      if (vout !== prev) begin
        `CHK(vout, prev + 6'h01);
        if (last != 0) `CHK(n - last, STEP)
        last = n;
        prev = vout;
      end
    end
    if (prev !== c) begin
      $display("[ERR] %0t ramp timeout", $time);
      err_count++;
      complete_run();
    end
  endtask

  task automatic t_ramp();
    logic ack;
    host.set_ptr(8'h01, ack);
    host.wr(8'h40);
    host.wr(8'h6A);
    @(posedge clk);
    #1;
    `CHK(busy, 1'b1);
    wait_code(6'h2A);
    @(posedge clk);
    #1;
    `CHK(busy, 1'b0);
    host.set_ptr(8'h02, ack);
    host.wr(8'h6E);
    wait_code(6'h2B);
    host.set_ptr(8'h02, ack);
    host.wr(8'h50);
    @(posedge clk);
    #1;
    `CHK({busy, vout}, 7'h10);
    host.set_ptr(8'h01, ack);
    host.wr(8'h00);
    host.wr(8'h7F);
    @(posedge clk);
    #1;
    `CHK({busy, vout}, 7'h2E);
  endtask

  task automatic freq_step(input logic [11:0] f, input logic exp);
    @(posedge clk);
    freq <= f;
    @(posedge clk);
    #1;
    `CHK(all_on, exp);
  endtask

  task automatic t_freq();
    logic ack;
    for (int s = 0; s < 4; s++) begin
      host.set_ptr(8'h02, ack);
      host.wr({s[1:0], 6'h10});
      `CHK(thr, s[1:0]);
      freq_step(RISE_T[s*12 +: 12] + 12'h001, 1'b1);
      freq_step(RISE_T[s*12 +: 12], 1'b1);
      freq_step(FALL_T[s*12 +: 12] + 12'h001, 1'b1);
      freq_step(FALL_T[s*12 +: 12], 1'b0);
      freq_step(RISE_T[s*12 +: 12], 1'b0);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_version();
    t_burst();
    t_latched();
    t_ramp();
    t_freq();
    complete_run();
  end
endmodule
